// ==== logic/ipc_regs.vh ====
`ifndef IPC_REGS_VH
`define IPC_REGS_VH
`define IPC_PRIO_ADDR     8'hb8
`define IPC_ENABLE_ADDR   8'ha8
`define IPC_PWR_ADDR      8'h87
`define IPC_PRIO_RESET    8'h80
`define IPC_PRIO_FIXED    8'h80
`define IPC_ENABLE_RESET  8'h00
`define IPC_PWR_RESET     8'h00
`define IPC_PWR_IDLE_BIT  0
`define IPC_PWR_STOP_BIT  1
`define IPC_EA_BIT        7
`define IPC_NUM_SRC       7
`define IPC_RESET_VECTOR  16'h0000
`define IPC_MAX_LATENCY   18
`endif

// ==== logic/ipc_ctrl.v ====
`timescale 1ns/100ps
`default_nettype none
`include "ipc_regs.vh"
// Interrupt priority and power-mode controller for an 8-bit core.
module ipc_ctrl #(
    parameter NUM_SRC = `IPC_NUM_SRC
) (
    input  wire        core_clk_in,
    input  wire        rst_n_in,
    input  wire        ext_rst_in,
    input  wire        watchdog_rst_in,
    input  wire        missing_clock_rst_in,
    input  wire        sfr_wr_in,
    input  wire        sfr_rd_in,
    input  wire [7:0]  sfr_addr_in,
    input  wire [7:0]  sfr_wdata_in,
    // Core sequencer handshake
    input  wire        instr_done_in,
    input  wire        irq_return_done_in,
    input  wire        vector_taken_in,
    // Peripheral request flags
    input  wire        ext_irq0_flag_in,
    input  wire        timer0_overflow_flag_in,
    input  wire        ext_irq1_flag_in,
    input  wire        timer1_overflow_flag_in,
    input  wire        uart_rx_flag_in,
    input  wire        uart_tx_flag_in,
    input  wire        timer2_high_overflow_in,
    input  wire        timer2_low_overflow_in,
    input  wire        spi_done_flag_in,
    input  wire        spi_write_collision_in,
    input  wire        spi_mode_fault_in,
    input  wire        spi_rx_overrun_in,
    output reg  [7:0]  sfr_rdata_out,
    output wire        sfr_hit_out,
    output reg         cpu_halt_out,
    output reg         osc_stop_out,
    output reg         periph_stop_out,
    output reg         core_reset_out,
    output reg  [15:0] fetch_addr_out,
    output wire        irq_req_out,
    output wire [2:0]  irq_src_out,
    output wire        irq_high_out,
    output reg  [1:0]  active_levels_out
);

    // Run executes, Idle halts only the core, Stop halts clocks too;
    // Stop is left by a reset alone, Idle also by an enabled request.
    // Any other code falls back to Run.
    localparam ST_RUN  = 2'h0;
    localparam ST_IDLE = 2'h1;
    localparam ST_STOP = 2'h2;

    reg  [7:0]         prio_ff;
    reg  [7:0]         enable_ff;
    reg  [1:0]         pwr_ff;
    reg  [1:0]         state_ff;
    reg  [1:0]         nxt_state;
    reg  [1:0]         inservice_ff;
    reg                hold_ff;
    wire               reg_wr;
    wire [1:0]         reg_sel;
    wire [NUM_SRC-1:0] raw_req;
    wire [NUM_SRC-1:0] gated_req;
    wire [NUM_SRC-1:0] hi_req;
    wire [NUM_SRC-1:0] lo_req;
    wire               any_rst;
    wire               sel_hi;
    wire [2:0]         sel_src;
    wire               can_take;
    wire               cand;

    // Lowest set bit index; shared by both priority levels
    function [3:0] ipc_first;
        input [NUM_SRC-1:0] vec;
        integer i;
        begin
            ipc_first = 4'hf;
            for (i = NUM_SRC - 1; i >= 0; i = i - 1) begin
                if (vec[i]) begin
                    ipc_first = i[3:0];
                end
            end
        end
    endfunction

    // Register select from the address: 1 priority, 2 enable, 3 power
    function [1:0] ipc_reg_sel;
        input [7:0] addr;
        begin
            case (addr)
                `IPC_PRIO_ADDR:   ipc_reg_sel = 2'h1;
                `IPC_ENABLE_ADDR: ipc_reg_sel = 2'h2;
                `IPC_PWR_ADDR:    ipc_reg_sel = 2'h3;
                default:          ipc_reg_sel = 2'h0;
            endcase
        end
    endfunction

    // Winner inside each level
    wire [3:0] hi_idx = ipc_first(hi_req);
    wire [3:0] lo_idx = ipc_first(lo_req);

    // Reset sources carry no enable and no level
    assign any_rst = ext_rst_in | watchdog_rst_in
                   | missing_clock_rst_in;

    // Shared sources raise one request from any of their flags
    assign raw_req[0] = ext_irq0_flag_in;
    assign raw_req[1] = timer0_overflow_flag_in;
    assign raw_req[2] = ext_irq1_flag_in;
    assign raw_req[3] = timer1_overflow_flag_in;
    assign raw_req[4] = uart_rx_flag_in | uart_tx_flag_in;
    assign raw_req[5] = timer2_high_overflow_in
                      | timer2_low_overflow_in;
    assign raw_req[6] = spi_done_flag_in | spi_write_collision_in
                      | spi_mode_fault_in | spi_rx_overrun_in;

    // Per-source enable gate, then split by priority level
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g = g + 1) begin : g_src
            assign gated_req[g] = raw_req[g] & enable_ff[g];
            assign hi_req[g] = gated_req[g] & prio_ff[g];
            assign lo_req[g] = gated_req[g] & ~prio_ff[g];
        end
    endgenerate

    // Global enable bit 7 of the enable register gates all vectoring
    assign sel_hi  = |hi_req;
    assign sel_src = sel_hi ? hi_idx[2:0] : lo_idx[2:0];
    assign can_take = sel_hi ? ~inservice_ff[1]
                             : (inservice_ff == 2'b00);
    assign cand = enable_ff[`IPC_EA_BIT] & (|gated_req)
                & can_take & ~hold_ff;
    // Request is combinational so detection adds no clock
    assign irq_req_out  = cand & (state_ff != ST_STOP)
                        & ~core_reset_out;
    assign irq_src_out  = sel_src;
    assign irq_high_out = sel_hi;
    assign reg_sel      = ipc_reg_sel(sfr_addr_in);
    assign sfr_hit_out  = (reg_sel != 2'h0);
    // Writes are refused while the core is halted
    assign reg_wr       = sfr_wr_in & (state_ff == ST_RUN);

    // Read mux; zero when not reading or not ours
    always @* begin
        sfr_rdata_out = 8'h00;
        if (sfr_rd_in) begin
            case (sfr_addr_in)
                `IPC_PRIO_ADDR:   sfr_rdata_out = prio_ff;
                `IPC_ENABLE_ADDR: sfr_rdata_out = enable_ff;
                `IPC_PWR_ADDR:    sfr_rdata_out = {6'h00, pwr_ff};
                default:          sfr_rdata_out = 8'h00;
            endcase
        end
    end

    // Mode changes wait for the selecting instruction to finish;
    // stop wins when both selects are set.
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_RUN: begin
                if (instr_done_in && pwr_ff[`IPC_PWR_STOP_BIT]) begin
                    nxt_state = ST_STOP;
                end else if (instr_done_in
                             && pwr_ff[`IPC_PWR_IDLE_BIT]) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (cand) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_STOP: nxt_state = ST_STOP;
            default: nxt_state = ST_RUN;
        endcase
    end

    // Any reset source puts the core back at its reset vector
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            core_reset_out <= 1'b1;
            fetch_addr_out <= `IPC_RESET_VECTOR;
        end else if (any_rst) begin
            core_reset_out <= 1'b1;
            fetch_addr_out <= `IPC_RESET_VECTOR;
        end else begin
            core_reset_out <= 1'b0;
            fetch_addr_out <= `IPC_RESET_VECTOR;
        end
    end

    // Priority levels; bit 7 stays at one whatever is written
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prio_ff <= `IPC_PRIO_RESET;
        end else if (any_rst) begin
            prio_ff <= `IPC_PRIO_RESET;
        end else if (reg_wr && reg_sel == 2'h1) begin
            prio_ff <= sfr_wdata_in | `IPC_PRIO_FIXED;
        end
    end

    // Source enables plus the global enable in bit 7
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            enable_ff <= `IPC_ENABLE_RESET;
        end else if (any_rst) begin
            enable_ff <= `IPC_ENABLE_RESET;
        end else if (reg_wr && reg_sel == 2'h2) begin
            enable_ff <= sfr_wdata_in;
        end
    end

    // Idle and stop selects; a wake from Idle drops the idle select
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pwr_ff <= 2'h0;
        end else if (any_rst) begin
            pwr_ff <= 2'h0;
        end else if (state_ff == ST_IDLE && cand) begin
            pwr_ff[`IPC_PWR_IDLE_BIT] <= 1'b0;
        end else if (reg_wr && reg_sel == 2'h3) begin
            pwr_ff <= sfr_wdata_in[1:0];
        end
    end

    // Halt lines only freeze the core, and in Stop also the clock and peripherals; no register is cleared on entry
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_ff        <= ST_RUN;
            cpu_halt_out    <= 1'b0;
            osc_stop_out    <= 1'b0;
            periph_stop_out <= 1'b0;
        end else if (any_rst) begin
            state_ff        <= ST_RUN;
            cpu_halt_out    <= 1'b0;
            osc_stop_out    <= 1'b0;
            periph_stop_out <= 1'b0;
        end else begin
            state_ff        <= nxt_state;
            cpu_halt_out    <= (nxt_state != ST_RUN);
            osc_stop_out    <= (nxt_state == ST_STOP);
            periph_stop_out <= (nxt_state == ST_STOP);
        end
    end

    // In-service levels: set on vector, clear the top one on return
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            inservice_ff <= 2'b00;
        end else if (any_rst) begin
            inservice_ff <= 2'b00;
        end else if (vector_taken_in) begin
            if (sel_hi) begin
                inservice_ff[1] <= 1'b1;
            end else begin
                inservice_ff[0] <= 1'b1;
            end
        end else if (irq_return_done_in) begin
            if (inservice_ff[1]) begin
                inservice_ff[1] <= 1'b0;
            end else begin
                inservice_ff[0] <= 1'b0;
            end
        end
    end

    // After a return one more instruction must finish before vectoring
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hold_ff <= 1'b0;
        end else if (any_rst) begin
            hold_ff <= 1'b0;
        end else if (irq_return_done_in) begin
            hold_ff <= 1'b1;
        end else if (hold_ff && instr_done_in) begin
            hold_ff <= 1'b0;
        end
    end

    // Reported in-service bits trail the internal ones by a cycle
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            active_levels_out <= 2'b00;
        end else if (any_rst) begin
            active_levels_out <= 2'b00;
        end else begin
            active_levels_out <= inservice_ff;
        end
    end

endmodule // ipc_ctrl
`default_nettype wire

// ==== test/ipc_ctrl_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
module ipc_ctrl_chk #(
    parameter NUM_SRC = 7
) (
    input wire logic       core_clk_in,
    input wire logic       rst_n_in,
    input wire logic       ext_rst_in,
    input wire logic       watchdog_rst_in,
    input wire logic       missing_clock_rst_in,
    input wire logic       irq_return_done_in,
    input wire logic       vector_taken_in,
    input wire logic       cpu_halt_out,
    input wire logic       osc_stop_out,
    input wire logic       periph_stop_out,
    input wire logic       core_reset_out,
    input wire logic       irq_req_out,
    input wire logic [2:0] irq_src_out,
    input wire logic       irq_high_out,
    input wire logic [1:0] active_levels_out
);
    wire any_rst = ext_rst_in | watchdog_rst_in | missing_clock_rst_in;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_idle; cpu_halt_out && !osc_stop_out; endsequence
    sequence s_stopped; osc_stop_out && !any_rst; endsequence
    property p_rst; any_rst |=> core_reset_out && !cpu_halt_out; endproperty
    a_rst: assert property (p_rst) else $error("reset not taken");
    property p_stop; s_stopped |=> osc_stop_out && cpu_halt_out; endproperty
    a_stop: assert property (p_stop) else $error("stop left early");
    property p_all; osc_stop_out |-> cpu_halt_out && periph_stop_out; endproperty
    a_all: assert property (p_all) else $error("stop incomplete");
    property p_idle; s_idle |-> !periph_stop_out; endproperty
    a_idle: assert property (p_idle) else $error("idle stopped units");
    property p_wake; s_idle ##0 irq_req_out |=> !cpu_halt_out; endproperty
    a_wake: assert property (p_wake) else $error("idle not woken");
    property p_ret_hold; irq_return_done_in |=> !irq_req_out; endproperty
    a_ret_hold: assert property (p_ret_hold) else $error("request after return");
    property p_busy;
        active_levels_out[1] && !$past(irq_return_done_in) |-> !irq_req_out;
    endproperty
    a_busy: assert property (p_busy) else $error("high handler cut in");
    property p_vec;
        vector_taken_in && irq_high_out |-> ##[1:2] active_levels_out[1];
    endproperty
    a_vec: assert property (p_vec) else $error("high level not held");
    property p_src; irq_req_out |-> irq_src_out < NUM_SRC; endproperty
    a_src: assert property (p_src) else $error("bad source");
endmodule // ipc_ctrl_chk
bind ipc_ctrl ipc_ctrl_chk #(.NUM_SRC(NUM_SRC)) ipc_ctrl_chk_inst (.*);
`default_nettype wire

// ==== test/ipc_cpu_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module ipc_cpu_model (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic run_in,
    input  wire logic irq_req_in,
    input  wire logic halt_in,
    output wire logic instr_done_out,
    output wire logic vector_taken_out,
    output wire logic irq_return_done_out
);
    logic [3:0] isr_cnt_ff;
    wire        go = run_in & ~halt_in;
    // Count 1 is the vectoring cycle, 15 the return; no nesting
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            isr_cnt_ff <= 4'h0;
        end else if (go && (isr_cnt_ff != 4'h0 || irq_req_in)) begin
            isr_cnt_ff <= isr_cnt_ff + 4'h1;
        end
    end
    assign vector_taken_out = go & (isr_cnt_ff == 4'h1);
    assign irq_return_done_out = go & (isr_cnt_ff == 4'hf);
    assign instr_done_out   = go & (isr_cnt_ff == 4'h0);
endmodule // ipc_cpu_model
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        core_clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        ext_rst_in = 1'b0;
    logic        watchdog_rst_in = 1'b0;
    logic        missing_clock_rst_in = 1'b0;
    logic        sfr_wr_in = 1'b0;
    logic        sfr_rd_in = 1'b0;
    logic        run = 1'b0;
    logic [7:0]  sfr_addr_in = 8'h00;
    logic [7:0]  sfr_wdata_in = 8'h00;
    logic [11:0] fl = 12'h000;
    wire         instr_done_in, irq_return_done_in, vector_taken_in;
    wire         sfr_hit_out;
    wire         cpu_halt_out, osc_stop_out, periph_stop_out, core_reset_out;
    wire         irq_req_out, irq_high_out;
    wire  [7:0]  sfr_rdata_out;
    wire  [15:0] fetch_addr_out;
    wire  [2:0]  irq_src_out;
    wire  [1:0]  active_levels_out;
    int          err_total = 0;
    int          n_compared = 0;
    // Arbitrary address of the reference control register, not ours
    localparam logic [7:0] vref_ctrl_addr = 8'hd1;
    // enable, priority, flags, {request, source}, high
    logic [32:0] rows [12] = '{
        {8'h81, 8'h80, 12'h001, 4'h8, 1'b0}, {8'hff, 8'h80, 12'hfff, 4'h8, 1'b0},
        {8'hff, 8'hc0, 12'hfff, 4'he, 1'b1}, {8'h7f, 8'hff, 12'hfff, 4'h0, 1'b0},
        {8'h90, 8'h90, 12'h020, 4'hc, 1'b1}, {8'hb0, 8'ha0, 12'h050, 4'hd, 1'b1},
        {8'ha0, 8'h80, 12'h080, 4'hd, 1'b0}, {8'hc0, 8'h80, 12'h800, 4'he, 1'b0},
        {8'hc0, 8'h80, 12'h200, 4'he, 1'b0}, {8'hbf, 8'h80, 12'h400, 4'h0, 1'b0},
        {8'h8f, 8'h88, 12'h00a, 4'hb, 1'b1}, {8'h84, 8'h84, 12'h104, 4'ha, 1'b1}};
    ipc_ctrl ipc_ctrl_inst (
        .ext_irq0_flag_in(fl[0]), .timer0_overflow_flag_in(fl[1]),
        .ext_irq1_flag_in(fl[2]), .timer1_overflow_flag_in(fl[3]),
        .uart_rx_flag_in(fl[4]), .uart_tx_flag_in(fl[5]),
        .timer2_high_overflow_in(fl[6]), .timer2_low_overflow_in(fl[7]),
        .spi_done_flag_in(fl[8]), .spi_write_collision_in(fl[9]),
        .spi_mode_fault_in(fl[10]), .spi_rx_overrun_in(fl[11]), .*);
    ipc_cpu_model ipc_cpu_model_inst (
        .clk_in(core_clk_in), .rst_n_in(rst_n_in), .run_in(run),
        .irq_req_in(irq_req_out), .halt_in(cpu_halt_out),
        .instr_done_out(instr_done_in), .vector_taken_out(vector_taken_in),
        .irq_return_done_out(irq_return_done_in));
    always #5 core_clk_in = ~core_clk_in;
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        sfr_wr_in <= 1'b1;
        sfr_addr_in <= a;
        sfr_wdata_in <= d;
        @(posedge core_clk_in);
        sfr_wr_in <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk_in);
        sfr_rd_in <= 1'b1;
        sfr_addr_in <= a;
        #1 chk("read data", {8'h00, e}, {8'h00, sfr_rdata_out});
        @(posedge core_clk_in);
        sfr_rd_in <= 1'b0;
    endtask
    task do_reset;
        @(posedge core_clk_in);
        rst_n_in <= 1'b0;
        run <= 1'b0;
        fl <= 12'h000;
        repeat (5) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        repeat (2) @(posedge core_clk_in);
    endtask
    function automatic logic pick(input int s);
        return s == 0 ? vector_taken_in : s == 1 ? irq_return_done_in :
               s == 2 ? cpu_halt_out : !cpu_halt_out;
    endfunction
    task wait_for(input int s);
        #1;
        for (int n = 0; n < 30 && pick(s) !== 1'b1; n++) begin
            @(posedge core_clk_in);
            #1;
        end
        chk("awaited event", 16'h1, {15'h0, pick(s)});
    endtask
    task wrap_up;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge core_clk_in);
        err_total++;
        wrap_up;
    end
    initial begin
        do_reset;
        rd(8'hb8, 8'h80);
        #1 chk("decode hit", 16'h1, {15'h0, sfr_hit_out});
        rd(8'ha8, 8'h00);
        wr(8'hb8, 8'h00);
        rd(8'hb8, 8'h80);
        wr(8'hb8, 8'h7f);
        rd(8'hb8, 8'hff);
        rd(8'h10, 8'h00);
        #1 chk("decode miss", 16'h0, {15'h0, sfr_hit_out});
        foreach (rows[i]) begin
            wr(8'ha8, rows[i][32:25]);
            wr(8'hb8, rows[i][24:17]);
            @(posedge core_clk_in);
            fl <= rows[i][16:5];
            #1 chk("request", {15'h0, rows[i][4]}, {15'h0, irq_req_out});
            if (rows[i][4]) chk("winner", rows[i][3:0], {irq_src_out, irq_high_out});
        end
        do_reset;
        wr(8'ha8, 8'h83);
        wr(8'hb8, 8'h82);
        @(posedge core_clk_in);
        fl <= 12'h001;
        run <= 1'b1;
        wait_for(0);
        @(posedge core_clk_in);
        #1 chk("low in service", 16'h0, {15'h0, irq_req_out});
        @(posedge core_clk_in);
        fl <= 12'h003;
        #1 chk("preempt", 16'h3, {12'h0, irq_src_out, irq_high_out});
        wait_for(1);
        @(posedge core_clk_in);
        #1 chk("after return", 16'h0, {15'h0, irq_req_out});
        wait_for(0);
        repeat (2) @(posedge core_clk_in);
        #1 chk("high level", 16'h2, {14'h0, active_levels_out});
        for (int k = 0; k < 4; k++) begin
            do_reset;
            wr(8'ha8, 8'h81);
            @(posedge core_clk_in);
            run <= 1'b1;
            wr(vref_ctrl_addr, 8'h01);
            #1 chk("vref not ours", 16'h0, {15'h0, sfr_hit_out});
            wr(8'h87, k == 3 ? 8'h02 : 8'h01);
            wait_for(2);
            chk("stop lines", k == 3 ? 16'h3 : 16'h0, {osc_stop_out, periph_stop_out});
            @(posedge core_clk_in);
            fl <= {11'h0, k == 0 || k == 3};
            if (k == 0) begin
                wait_for(3);
                rd(8'h87, 8'h00);
            end else begin
                repeat (4) @(posedge core_clk_in);
                #1 chk("still halted", 16'h1, {15'h0, cpu_halt_out});
                @(posedge core_clk_in);
                {missing_clock_rst_in, watchdog_rst_in, ext_rst_in} <= 3'h1 << (k - 1);
                @(posedge core_clk_in);
                {missing_clock_rst_in, watchdog_rst_in, ext_rst_in} <= 3'h0;
                #1 chk("reset state", 16'h4, {core_reset_out, cpu_halt_out, osc_stop_out});
                chk("fetch address", 16'h0000, fetch_addr_out);
            end
        end
        wrap_up;
    end
endmodule // tb_top
`default_nettype wire
